//--- design/lsd_pkg.sv
// Constants, register map and field layout of the LED sink dimming control
// Assumes an 8-bit register port and a 10 MHz system clock
package lsd_pkg;

   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int REG_W         = 8;
   localparam int NUM_SINKS     = 8;
   localparam int NUM_BOUNDS    = 4;
   localparam int NUM_ZONES     = 5;
   localparam int ZONE_W        = 3;
   localparam int A_CODE_W      = 7;
   localparam int BC_CODE_W     = 3;
   localparam int BC_LVL_W      = 4;
   localparam int LVL_MIN_W     = 12;
   localparam int STAT_W        = 2;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DIODE_EN = 8'h10;
   localparam logic [7:0] ADDR_CONFIG   = 8'h20;
   localparam logic [7:0] ADDR_ZONE_RB  = 8'h40;
   localparam logic [7:0] ADDR_BOUND0   = 8'h60;
   localparam logic [7:0] ADDR_BRIGHT0  = 8'h70;
   localparam logic [7:0] ADDR_GRP_A    = 8'ha0;
   localparam logic [7:0] ADDR_GRP_B    = 8'hb0;
   localparam logic [7:0] ADDR_GRP_C    = 8'hc0;
   localparam logic [7:0] ADDR_INT_STAT = 8'he0;
   localparam logic [7:0] ADDR_INT_MASK = 8'he1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_DIODE_EN  = 8'h00;
   localparam logic [7:0] RST_CONFIG    = 8'h00;
   localparam logic [7:0] RST_GRP_A     = 8'h80;
   localparam logic [7:0] RST_GRP_B     = 8'hc0;
   localparam logic [7:0] RST_GRP_C     = 8'hf8;
   localparam logic [3:0] ZONE_RB_TOP   = 4'hf;
   localparam logic [NUM_BOUNDS-1:0][7:0] RST_BOUND =
      {8'hcc, 8'h99, 8'h66, 8'h33};
   localparam logic [NUM_ZONES-1:0][7:0] RST_BRIGHT =
      {8'hff, 8'he6, 8'hcc, 8'hb6, 8'h99};

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CFG_CHIP_EN     = 0;
   localparam int CFG_PWM_HONOUR  = 1;
   localparam int CFG_PWM_ACT_LOW = 2;
   localparam int CFG_AMB_EN      = 3;
   localparam int ST_ZONE         = 0;
   localparam int ST_GAIN         = 1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int PULSE_MIN_NS  = 15000;
   localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- design/lsd_zone_cmp.sv
// Ambient zone comparator: counts trip points below the ambient level
// Assumes trip points are programmed in ascending order
`timescale 1ns/1ns
module lsd_zone_cmp (
   input  wire logic [lsd_pkg::REG_W-1:0]                      level,
   input  wire logic [lsd_pkg::NUM_BOUNDS-1:0][lsd_pkg::REG_W-1:0] bounds,
   output logic      [lsd_pkg::ZONE_W-1:0]                     zone
);
   import lsd_pkg::*;

   // ----------------------------------------------------------------
   // Zone count
   // ----------------------------------------------------------------
   function automatic logic [ZONE_W-1:0] countAbove(
      input logic [REG_W-1:0]                  lvl,
      input logic [NUM_BOUNDS-1:0][REG_W-1:0]  b
   );
      logic [ZONE_W-1:0] n;
      n = '0;
      for (int i = 0; i < NUM_BOUNDS; i++) begin
         if (lvl > b[i]) begin
            n = n + 3'h1;
         end
      end
      return n;
   endfunction

   // Four trip points give zones 0 to 4, one per brightness setting
   always_comb begin
      zone = countAbove(level, bounds);
   end

endmodule

//--- design/lsd_core.sv
// Control core of the LED sink dimming driver: registers, dimming gate,
// ambient zones, pump gain choice and interrupt
// Assumes register strobes and all inputs are synchronous to sys_clk
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
module lsd_core #(
   parameter int LVL_W = 12
) (
   input  wire logic                         sys_clk,
   input  wire logic                         nrst,
   input  wire logic                         hardwareEnablePin,
   input  wire logic [7:0]                   regAddr,
   input  wire logic [lsd_pkg::REG_W-1:0]    regWdata,
   input  wire logic                         regWr,
   input  wire logic                         regRd,
   output logic      [lsd_pkg::REG_W-1:0]    regRdata,
   input  wire logic [lsd_pkg::REG_W-1:0]    ambientLightInput,
   input  wire logic                         contentDrivenDimmingIn,
   input  wire logic [lsd_pkg::NUM_SINKS-1:0] headroomLow,
   output logic      [lsd_pkg::NUM_SINKS-1:0] sinkEnable,
   output logic      [LVL_W-1:0]             primaryLevel,
   output logic      [lsd_pkg::BC_LVL_W-1:0] secondLevel,
   output logic      [lsd_pkg::BC_LVL_W-1:0] thirdLevel,
   output logic      [lsd_pkg::ZONE_W-1:0]   ambientZone,
   output logic                              pumpGainHigh,
   output logic                              ambientIntOut,
   output logic                              ambientIntOe,
   output logic                              irq
);
   import lsd_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (LVL_W < LVL_MIN_W) begin : g_bad_width
         $error("LVL_W too narrow for the exponential level");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic hit(
      input logic       strobe,
      input logic [7:0] a,
      input logic [7:0] target
   );
      return strobe && (a == target);
   endfunction

   // Four-bit mantissa below a leading one, shifted by a three-bit exponent
   function automatic logic [LVL_W-1:0] expLevel(
      input logic [A_CODE_W-1:0] code
   );
      logic [LVL_W-1:0] m;
      m = {{(LVL_W-5){1'b0}}, 1'b1, code[3:0]};
      return m << code[A_CODE_W-1:4];
   endfunction

   function automatic logic [BC_LVL_W-1:0] linLevel(
      input logic [BC_CODE_W-1:0] code
   );
      return {1'b0, code} + 4'h1;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                                  clrAll;
   logic [REG_W-1:0]                      diodeEn_reg;
   logic [REG_W-1:0]                      config_reg;
   logic [REG_W-1:0]                      grpA_reg;
   logic [REG_W-1:0]                      grpB_reg;
   logic [REG_W-1:0]                      grpC_reg;
   logic [STAT_W-1:0]                     intMask_reg;
   logic [STAT_W-1:0]                     intStat_reg;
   logic [STAT_W-1:0]                     intStat_next;
   logic [NUM_BOUNDS-1:0][REG_W-1:0]      bound_reg;
   logic [NUM_ZONES-1:0][REG_W-1:0]       bright_reg;
   logic [ZONE_W-1:0]                     zoneNow;
   logic [ZONE_W-1:0]                     zone_reg;
   logic                                  zoneChange;
   logic                                  rdZone;
   logic                                  headWatch;
   logic                                  gain_next;
   logic                                  gainUp;
   logic                                  sinkGate;
   logic [A_CODE_W-1:0]                   primaryCode;
   logic [REG_W-1:0]                      rdMux;

   // Enable pin low acts as a second synchronous reset
   assign clrAll = !nrst || !hardwareEnablePin;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (clrAll) begin
         diodeEn_reg <= RST_DIODE_EN;
         config_reg  <= RST_CONFIG;
         grpA_reg    <= RST_GRP_A;
         grpB_reg    <= RST_GRP_B;
         grpC_reg    <= RST_GRP_C;
         intMask_reg <= '0;
      end else begin
         if (hit(regWr, regAddr, ADDR_DIODE_EN)) begin
            diodeEn_reg <= regWdata;
         end
         if (hit(regWr, regAddr, ADDR_CONFIG)) begin
            config_reg <= regWdata;
         end
         if (hit(regWr, regAddr, ADDR_GRP_A)) begin
            grpA_reg <= regWdata;
         end
         if (hit(regWr, regAddr, ADDR_GRP_B)) begin
            grpB_reg <= regWdata;
         end
         if (hit(regWr, regAddr, ADDR_GRP_C)) begin
            grpC_reg <= regWdata;
         end
         if (hit(regWr, regAddr, ADDR_INT_MASK)) begin
            intMask_reg <= regWdata[STAT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Trip points and zone brightness codes
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (clrAll) begin
         bound_reg  <= RST_BOUND;
         bright_reg <= RST_BRIGHT;
      end else begin
         for (int i = 0; i < NUM_BOUNDS; i++) begin
            if (hit(regWr, regAddr, ADDR_BOUND0 + 8'(i))) begin
               bound_reg[i] <= regWdata;
            end
         end
         for (int i = 0; i < NUM_ZONES; i++) begin
            if (hit(regWr, regAddr, ADDR_BRIGHT0 + 8'(i))) begin
               bright_reg[i] <= regWdata;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Ambient zone tracking
   // ----------------------------------------------------------------
   lsd_zone_cmp u_zone (
      .level  (ambientLightInput),
      .bounds (bound_reg),
      .zone   (zoneNow)
   );

   assign zoneChange = config_reg[CFG_AMB_EN] && (zoneNow != zone_reg);
   assign rdZone     = hit(regRd, regAddr, ADDR_ZONE_RB);

   always_ff @(posedge sys_clk) begin
      if (clrAll) begin
         zone_reg <= '0;
      end else begin
         zone_reg <= zoneNow;
      end
   end

   // ----------------------------------------------------------------
   // Pump gain
   // ----------------------------------------------------------------
   // Only sinks that are currently driven are watched
   assign headWatch = |(headroomLow & sinkEnable);

   always_comb begin
      gain_next = pumpGainHigh;
      if (regWr) begin
         gain_next = headWatch;
      end else if (headWatch) begin
         gain_next = 1'b1;
      end
   end

   assign gainUp = !pumpGainHigh && gain_next;

   always_ff @(posedge sys_clk) begin
      if (clrAll) begin
         pumpGainHigh <= 1'b0;
      end else begin
         pumpGainHigh <= gain_next;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------
   // New events win over a clear in the same cycle
   always_comb begin
      intStat_next = intStat_reg;
      if (hit(regWr, regAddr, ADDR_INT_STAT)) begin
         intStat_next = intStat_next & ~regWdata[STAT_W-1:0];
      end
      if (rdZone) begin
         intStat_next[ST_ZONE] = 1'b0;
      end
      if (zoneChange) begin
         intStat_next[ST_ZONE] = 1'b1;
      end
      if (gainUp) begin
         intStat_next[ST_GAIN] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clrAll) begin
         intStat_reg   <= '0;
         irq           <= 1'b0;
         ambientIntOe  <= 1'b0;
         ambientIntOut <= 1'b0;
      end else begin
         intStat_reg   <= intStat_next;
         irq           <= |(intStat_reg & intMask_reg);
         ambientIntOe  <= intStat_reg[ST_ZONE];
         ambientIntOut <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Sink outputs
   // ----------------------------------------------------------------
   // Ignored input leaves the gate open; otherwise follow active phase
   assign sinkGate = !config_reg[CFG_PWM_HONOUR] ||
      (contentDrivenDimmingIn ^ config_reg[CFG_PWM_ACT_LOW]);

   // Ambient mode takes the zone code, otherwise the host code
   assign primaryCode = config_reg[CFG_AMB_EN] ?
      bright_reg[zone_reg][A_CODE_W-1:0] : grpA_reg[A_CODE_W-1:0];

   always_ff @(posedge sys_clk) begin
      if (clrAll) begin
         sinkEnable   <= '0;
         primaryLevel <= '0;
         secondLevel  <= '0;
         thirdLevel   <= '0;
         ambientZone  <= '0;
      end else begin
         sinkEnable   <= (config_reg[CFG_CHIP_EN] && sinkGate) ? diodeEn_reg : '0;
         primaryLevel <= expLevel(primaryCode);
         secondLevel  <= linLevel(grpB_reg[BC_CODE_W-1:0]);
         thirdLevel   <= linLevel(grpC_reg[BC_CODE_W-1:0]);
         ambientZone  <= zone_reg;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_comb begin
      rdMux = '0;
      case (regAddr)
         ADDR_DIODE_EN: rdMux = diodeEn_reg;
         ADDR_CONFIG:   rdMux = config_reg;
         ADDR_ZONE_RB:  rdMux = {ZONE_RB_TOP, 1'b0, zone_reg};
         ADDR_GRP_A:    rdMux = grpA_reg;
         ADDR_GRP_B:    rdMux = grpB_reg;
         ADDR_GRP_C:    rdMux = grpC_reg;
         ADDR_INT_STAT: rdMux = {{(REG_W-STAT_W){1'b0}}, intStat_reg};
         ADDR_INT_MASK: rdMux = {{(REG_W-STAT_W){1'b0}}, intMask_reg};
         default: begin
            for (int i = 0; i < NUM_BOUNDS; i++) begin
               if (regAddr == ADDR_BOUND0 + 8'(i)) begin
                  rdMux = bound_reg[i];
               end
            end
            for (int i = 0; i < NUM_ZONES; i++) begin
               if (regAddr == ADDR_BRIGHT0 + 8'(i)) begin
                  rdMux = bright_reg[i];
               end
            end
         end
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge sys_clk) begin
      if (clrAll) begin
         regRdata <= '0;
      end else begin
         regRdata <= regRd ? rdMux : '0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (clrAll);

   property p_exp_level;
      !clrAll && !config_reg[CFG_AMB_EN] |=> primaryLevel == expLevel($past(grpA_reg[A_CODE_W-1:0]));
   endproperty
   a_exp_level: assert property (p_exp_level) else $error("primary level mismatch");

   property p_lin_level;
      !clrAll && hit(regWr, regAddr, ADDR_GRP_B) |=> grpB_reg == $past(regWdata)
         ##1 secondLevel == linLevel($past(regWdata[BC_CODE_W-1:0], 2));
   endproperty
   a_lin_level: assert property (p_lin_level) else $error("second level mismatch");

   property p_amb_level;
      config_reg[CFG_AMB_EN] |=> primaryLevel == expLevel($past(bright_reg[zone_reg][A_CODE_W-1:0]));
   endproperty
   a_amb_level: assert property (p_amb_level) else $error("zone level mismatch");

   property p_zone_int;
      zoneChange |=> intStat_reg[ST_ZONE] ##1 ambientIntOe;
   endproperty
   a_zone_int: assert property (p_zone_int) else $error("zone change not flagged");

   property p_int_release;
      rdZone && !zoneChange |-> ##2 !ambientIntOe;
   endproperty
   a_int_release: assert property (p_int_release) else $error("interrupt not released");

   property p_pwm_ignore;
      !config_reg[CFG_PWM_HONOUR] && config_reg[CFG_CHIP_EN] |=> sinkEnable == $past(diodeEn_reg);
   endproperty
   a_pwm_ignore: assert property (p_pwm_ignore) else $error("ignored input gated sinks");

   property p_pwm_off;
      config_reg[CFG_PWM_HONOUR] && (contentDrivenDimmingIn == config_reg[CFG_PWM_ACT_LOW])
         |=> sinkEnable == '0;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("sinks on in inactive phase");

   property p_pwm_on;
      config_reg[CFG_PWM_HONOUR] && config_reg[CFG_CHIP_EN] &&
         (contentDrivenDimmingIn != config_reg[CFG_PWM_ACT_LOW]) |=> sinkEnable == $past(diodeEn_reg);
   endproperty
   a_pwm_on: assert property (p_pwm_on) else $error("sinks off in active phase");

   property p_gain_hold;
      pumpGainHigh && !regWr |=> pumpGainHigh;
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("high gain left without write");

   property p_gain_eval;
      regWr |=> pumpGainHigh == $past(headWatch);
   endproperty
   a_gain_eval: assert property (p_gain_eval) else $error("gain not re-evaluated");

   property p_hw_reset;
      disable iff (!nrst)
      !hardwareEnablePin |=> sinkEnable == '0 && grpA_reg == RST_GRP_A && !pumpGainHigh;
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("enable pin low did not reset");

   property p_read_grp_a;
      !clrAll && hit(regRd, regAddr, ADDR_GRP_A) |=> regRdata == $past(grpA_reg)
         ##1 regRdata == '0 || $past(regRd);
   endproperty
   a_read_grp_a: assert property (p_read_grp_a) else $error("read data wrong");

endmodule

//--- sim/lsd_far_side.sv
// Far-side model: display driver dimming source and interrupt pull-up
// Assumes a 100 ns sys_clk and the open-drain pin split in data and enable
`timescale 1ns/1ns
module lsd_far_side (
   input  wire logic sys_clk,
   input  wire logic runPwm,
   input  wire logic idleLevel,
   input  wire logic ambientIntOut,
   input  wire logic ambientIntOe,
   output logic      dimOut,
   output logic      intPin
);
   import lsd_pkg::*;
   int unsigned phase = 0;
   initial dimOut = 1'b0;
   // Pull-up holds the pin high once the core lets go
   assign intPin = ambientIntOe ? ambientIntOut : 1'b1;
   // Pulses and gaps both last the minimum sink settle time
   always @(posedge sys_clk) begin
      if (!runPwm) begin
         phase  <= 0;
         dimOut <= idleLevel;
      end else begin
         phase  <= (phase + 1) % (2 * PULSE_MIN_CYC);
         dimOut <= (phase < PULSE_MIN_CYC);
      end
   end
endmodule

//--- sim/led_sink_dimming_control_tb_top.sv
// Testbench of the LED sink dimming core, register port tasks and scenarios
// Assumes lsd_pkg and the far-side model are compiled first
`timescale 1ns/1ns
module led_sink_dimming_control_tb_top;
   import lsd_pkg::*;
   logic        sys_clk           = 1'b0;
   logic        nrst              = 1'b0;
   logic        hardwareEnablePin = 1'b1;
   logic [7:0]  regAddr           = 8'h00;
   logic [7:0]  regWdata          = 8'h00;
   logic        regWr             = 1'b0;
   logic        regRd             = 1'b0;
   logic [7:0]  ambientLightInput = 8'h00;
   logic [7:0]  headroomLow       = 8'h00;
   logic        runPwm            = 1'b0;
   logic        idleLevel         = 1'b0;
   logic [7:0]  regRdata, sinkEnable, rdv;
   logic [11:0] primaryLevel;
   logic [3:0]  secondLevel, thirdLevel;
   logic [2:0]  ambientZone;
   logic        pumpGainHigh, ambientIntOut, ambientIntOe, irq, dimIn, intPin;
   int          num_errors = 0;
   int          checked    = 0;
   int          z;
   localparam logic [7:0] AMB [5] = '{8'hd0, 8'h34, 8'h99, 8'h9a, 8'h33};

   lsd_core #(.LVL_W(12)) lsd_core_inst (.sys_clk(sys_clk), .nrst(nrst),
      .hardwareEnablePin(hardwareEnablePin), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ambientLightInput(ambientLightInput),
      .contentDrivenDimmingIn(dimIn), .headroomLow(headroomLow), .sinkEnable(sinkEnable),
      .primaryLevel(primaryLevel), .secondLevel(secondLevel), .thirdLevel(thirdLevel),
      .ambientZone(ambientZone), .pumpGainHigh(pumpGainHigh), .ambientIntOut(ambientIntOut),
      .ambientIntOe(ambientIntOe), .irq(irq));
   lsd_far_side lsd_far_side_inst (.sys_clk(sys_clk), .runPwm(runPwm), .idleLevel(idleLevel),
      .ambientIntOut(ambientIntOut), .ambientIntOe(ambientIntOe), .dimOut(dimIn), .intPin(intPin));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   function automatic logic [15:0] expA(input logic [6:0] c);
      return 16'({1'b1, c[3:0]}) << c[6:4];
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr    <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge sys_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd   <= 1'b0;
      #1 rdv = regRdata;
      chk(rdv, e, what);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic reset_vals;
      rdchk(ADDR_DIODE_EN, RST_DIODE_EN, "diode en");
      rdchk(ADDR_CONFIG, RST_CONFIG, "config");
      rdchk(ADDR_GRP_A, RST_GRP_A, "group a");
      rdchk(ADDR_GRP_B, RST_GRP_B, "group b");
      rdchk(ADDR_GRP_C, RST_GRP_C, "group c");
      rdchk(ADDR_INT_STAT, 8'h00, "status");
      rdchk(ADDR_INT_MASK, 8'h00, "mask");
      rdchk(ADDR_ZONE_RB, {ZONE_RB_TOP, 4'h0}, "zone readback");
      for (int i = 0; i < NUM_BOUNDS; i++) rdchk(ADDR_BOUND0 + 8'(i), RST_BOUND[i], "bound");
      for (int i = 0; i < NUM_ZONES; i++) rdchk(ADDR_BRIGHT0 + 8'(i), RST_BRIGHT[i], "bright");
      chk(sinkEnable, 16'h0, "sinks off");
      chk(pumpGainHigh, 16'h0, "gain 1x");
      chk(primaryLevel, expA(RST_GRP_A[6:0]), "level 0");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      results();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      reset_vals();
      wr(8'h30, 8'hff);
      rdchk(8'h30, 8'h00, "unmapped");
      $display("test reset_values done");
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_GRP_B, 8'(c));
         wr(ADDR_GRP_C, 8'(7 - c));
         settle(2);
         chk(secondLevel, 16'(c + 1), "second level");
         chk(thirdLevel, 16'(8 - c), "third level");
      end
      for (int c = 1; c < 128; c += 9) begin
         wr(ADDR_GRP_A, 8'(c));
         settle(2);
         chk(primaryLevel, expA(7'(c)), "primary level");
      end
      $display("test brightness done");
      wr(ADDR_DIODE_EN, 8'ha5);
      for (int m = 0; m < 8; m++) begin
         wr(ADDR_CONFIG, 8'(m));
         for (int d = 0; d < 2; d++) begin
            @(posedge sys_clk);
            idleLevel <= d[0];
            settle(3);
            chk(sinkEnable, (m[0] && (!m[1] || (d[0] ^ m[2]))) ? 16'ha5 : 16'h0, "gate");
         end
      end
      wr(ADDR_CONFIG, 8'h03);
      runPwm <= 1'b1;
      @(posedge dimIn);
      settle(2);
      chk(sinkEnable, 16'ha5, "pulse on");
      @(negedge dimIn);
      settle(2);
      chk(sinkEnable, 16'h0, "pulse off");
      runPwm <= 1'b0;
      $display("test dimming done");
      wr(ADDR_CONFIG, 8'h09);
      wr(ADDR_INT_MASK, 8'h01);
      foreach (AMB[i]) begin
         @(posedge sys_clk);
         ambientLightInput <= AMB[i];
         settle(4);
         z = 0;
         for (int b = 0; b < NUM_BOUNDS; b++) if (RST_BOUND[b] < AMB[i]) z++;
         chk(ambientZone, 16'(z), "zone");
         chk(primaryLevel, expA(RST_BRIGHT[z][6:0]), "zone level");
         chk(intPin, 16'h0, "pin low");
         chk(irq, 16'h1, "irq set");
         rdchk(ADDR_ZONE_RB, {ZONE_RB_TOP, 1'b0, 3'(z)}, "zone readback");
         settle(2);
         chk(intPin, 16'h1, "pin released");
         chk(irq, 16'h0, "irq clear");
      end
      wr(ADDR_INT_MASK, 8'h00);
      ambientLightInput <= 8'hd0;
      settle(4);
      chk(intPin, 16'h0, "pin low masked");
      chk(irq, 16'h0, "irq masked");
      rdchk(ADDR_INT_STAT, 8'h01, "status zone");
      wr(ADDR_INT_STAT, 8'h01);
      settle(3);
      chk(intPin, 16'h1, "pin cleared");
      $display("test ambient done");
      wr(ADDR_CONFIG, 8'h01);
      headroomLow <= 8'h01;
      settle(3);
      chk(pumpGainHigh, 16'h1, "gain up");
      @(posedge sys_clk);
      headroomLow <= 8'h02;
      settle(5);
      chk(pumpGainHigh, 16'h1, "gain held");
      wr(ADDR_INT_MASK, 8'h02);
      settle(2);
      chk(pumpGainHigh, 16'h0, "gain redone");
      chk(irq, 16'h1, "gain irq");
      rdchk(ADDR_INT_STAT, 8'h02, "status gain");
      wr(ADDR_INT_STAT, 8'h02);
      settle(2);
      chk(irq, 16'h0, "gain irq clear");
      $display("test gain done");
      @(posedge sys_clk);
      headroomLow <= 8'h00;
      ambientLightInput <= 8'h00;
      hardwareEnablePin <= 1'b0;
      settle(2);
      chk(sinkEnable, 16'h0, "enable pin off");
      chk(ambientIntOe, 16'h0, "pin free");
      @(posedge sys_clk);
      hardwareEnablePin <= 1'b1;
      reset_vals();
      $display("test enable_pin done");
      results();
   end
endmodule
